/* ccg_pkg.sv */
package ccg_pkg;
   // ------------------------------------------------------------
   // Mode field
   // ------------------------------------------------------------
   localparam int MODE_W   = 3;
   localparam int MODE_MSB = 15;
   localparam int MODE_LSB = 13;
   localparam int CFG_MODE_MSB = 15;
   localparam int CFG_MODE_LSB = 13;
   localparam logic [2:0] MODE_RESET = 3'h7;

   typedef enum logic [2:0] {
      CCG_X2P5  = 3'h0,
      CCG_DIV2  = 3'h1,
      CCG_X1P5  = 3'h2,
      CCG_X1    = 3'h3,
      CCG_X5    = 3'h4,
      CCG_X2    = 3'h5,
      CCG_X3    = 3'h6,
      CCG_X4    = 3'h7
   } ccg_mode_e;

   // ------------------------------------------------------------
   // Factor as numerator over 2 (F = num / 2)
   // ------------------------------------------------------------
   localparam int NUM_W = 4;

   function automatic logic [3:0] ccg_factor_num(input logic [2:0] m);
      case (m)
         3'h7:    ccg_factor_num = 4'h8;
         3'h6:    ccg_factor_num = 4'h6;
         3'h5:    ccg_factor_num = 4'h4;
         3'h4:    ccg_factor_num = 4'hA;
         3'h3:    ccg_factor_num = 4'h2;
         3'h2:    ccg_factor_num = 4'h3;
         3'h0:    ccg_factor_num = 4'h5;
         default: ccg_factor_num = 4'h1;
      endcase
   endfunction
endpackage

/* ccg_mode_if.sv */
`timescale 1ns/1ps
interface ccg_mode_if;
   logic [2:0] mode;
   logic       pll_en;
   logic       direct;
   logic       presc;
   modport ctl (output mode, output pll_en, output direct, output presc);
   modport gen (input mode, input pll_en, input direct, input presc);
endinterface

/* ccg_mode_latch.sv */
`timescale 1ns/1ps
module ccg_mode_latch
   import ccg_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Pins and software reload
   input  wire logic [15:0] port0_pins,
   input  wire logic [15:0] reset_config_reg,
   input  wire logic        reload,
   // Decoded mode
   ccg_mode_if.ctl          mif
);
   import ccg_pkg::*;

   logic       rst_q;
   logic [2:0] port0_high_reset_image;

   always_ff @(posedge ref_clk) begin
      rst_q <= sys_rst;
   end

   // Held during reset, sampled on release; undefined before the first release
   always_ff @(posedge ref_clk) begin
      if (rst_q && !sys_rst) begin
         port0_high_reset_image <= port0_pins[MODE_MSB:MODE_LSB]; // RULE1 RULE7
      end else if (sys_rst) begin
         port0_high_reset_image <= port0_high_reset_image; // RULE7
      end else if (reload) begin
         port0_high_reset_image <= reset_config_reg[CFG_MODE_MSB:CFG_MODE_LSB]; // RULE1
      end
   end

   always_comb begin
      mif.mode   = port0_high_reset_image;
      mif.presc  = (port0_high_reset_image == CCG_DIV2); // RULE2
      mif.direct = (port0_high_reset_image == CCG_X1);   // RULE2
      mif.pll_en = !mif.presc && !mif.direct;           // RULE5
   end
endmodule

/* ccg_clock_gen.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Mode bits come from port0 pins 15..13; software may reload from config upper half.
// RULE2 - Codes 111..000 give x4,x3,x2,x5,x1,x1.5,/2,x2.5.
// RULE3 - Code 001 divides oscillator by two through a prescaler.
// RULE4 - Prescaler high and low phases each last one oscillator period.
// RULE5 - Multiplying codes enable the loop which sources the CPU clock at F times.
// RULE6 - Loop realigns to oscillator every F transitions, adjusting period gradually; the loop here realigns every 2F transitions.
// RULE7 - Mode pins sampled at reset release; prior selection kept during reset.
//
// ref_clk models a fast internal reference; osc_in is a synchronous sampled
// oscillator level. The loop is a digital NCO whose half period is nudged by at
// most one reference cycle per realignment, so the output never jumps in rate.
module ccg_clock_gen
   import ccg_pkg::*;
#(
   parameter int PER_W     = 16,
   parameter int HALF_INIT = 8
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Oscillator and configuration
   input  wire logic        osc_in,
   input  wire logic [15:0] port0_pins,
   input  wire logic [15:0] reset_config_reg,
   input  wire logic        reload,
   // Outputs
   output logic             cpu_clk,
   output logic [2:0]       clock_mode_select,
   output logic             pll_active,
   output logic             pll_locked
);
   import ccg_pkg::*;

   // ------------------------------------------------------------
   // Mode capture
   // ------------------------------------------------------------
   ccg_mode_if mif ();

   ccg_mode_latch u_latch (
      .ref_clk          (ref_clk),
      .sys_rst          (sys_rst),
      .port0_pins       (port0_pins),
      .reset_config_reg (reset_config_reg),
      .reload           (reload),
      .mif              (mif)
   );

   // ------------------------------------------------------------
   // Oscillator edge detect
   // ------------------------------------------------------------
   logic osc_q;
   logic osc_edge;
   logic osc_rise;

   // No reset on purpose: a cleared copy would fake an edge at release
   always_ff @(posedge ref_clk) begin
      osc_q <= osc_in;
   end

   assign osc_edge = osc_in ^ osc_q;
   assign osc_rise = osc_in & ~osc_q;

   // ------------------------------------------------------------
   // Prescaler: toggle on each oscillator rising edge
   // ------------------------------------------------------------
   logic presc_clk;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mif.presc)  presc_clk <= 1'b0;
      else if (osc_rise)          presc_clk <= ~presc_clk; // RULE3 RULE4
   end

   // ------------------------------------------------------------
   // Loop: measure 2F oscillator transitions, steer NCO half period
   // ------------------------------------------------------------
   logic [3:0]       trans_cnt;
   logic [PER_W-1:0] win_cnt;
   logic [PER_W-1:0] half_per;
   logic [PER_W-1:0] next_half_per;
   logic [PER_W-1:0] nco_cnt;
   logic             nco_clk;
   logic [PER_W-1:0] target;
   logic             realign;
   logic [2:0]       mode_q;
   logic             mode_chg;
   logic             win_full;
   logic [3:0]       num;
   logic [7:0]       num_sq;
   logic [PER_W:0]   win_x2;
   logic [PER_W:0]   quot;

   // ------------------------------------------------------------
   // Mode change tracking
   // ------------------------------------------------------------
   // A new factor makes the running window meaningless
   always_ff @(posedge ref_clk) begin
      mode_q <= mif.mode;
   end

   assign mode_chg = (mif.mode != mode_q);

   // ------------------------------------------------------------
   // Window and target
   // ------------------------------------------------------------
   // num = 2F transitions span F oscillator periods, that is 2F*F output half periods
   assign num     = ccg_factor_num(mif.mode);
   assign num_sq  = {4'h0, num} * {4'h0, num};
   assign realign = mif.pll_en && osc_edge && (trans_cnt == num - 4'h1);
   assign win_x2  = {win_cnt, 1'b0};
   assign quot    = win_x2 / {{(PER_W - 7){1'b0}}, num_sq};
   assign target  = quot[PER_W-1:0];

   // Window length counts the closing cycle too, so it restarts at one
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mif.pll_en || mode_chg) begin
         trans_cnt <= 4'h0;
         win_cnt   <= '0;
      end else if (realign) begin
         trans_cnt <= 4'h0; // RULE6
         win_cnt   <= PER_W'(1);
      end else begin
         if (osc_edge) trans_cnt <= trans_cnt + 4'h1;
         win_cnt <= win_cnt + PER_W'(1);
      end
   end

   // First window after a change starts mid-stream, so it only arms the loop
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mif.pll_en || mode_chg) begin
         win_full <= 1'b0;
      end else if (realign) begin
         win_full <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Half period steering
   // ------------------------------------------------------------
   // Only one step per window: trades lock speed for no abrupt change
   always_comb begin
      next_half_per = half_per;
      if (realign && win_full) begin
         if (target > half_per && half_per != '1) begin
            next_half_per = half_per + PER_W'(1); // RULE6
         end else if (target < half_per && half_per > PER_W'(1)) begin
            next_half_per = half_per - PER_W'(1); // RULE6
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         half_per <= PER_W'(HALF_INIT);
      end else begin
         half_per <= next_half_per;
      end
   end

   // ------------------------------------------------------------
   // Lock indication
   // ------------------------------------------------------------
   // Cleared on a mode change so a stale lock never covers a new factor
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mif.pll_en || mode_chg) begin
         pll_locked <= 1'b0;
      end else if (realign && win_full) begin
         pll_locked <= (target == half_per); // RULE6
      end
   end

   // ------------------------------------------------------------
   // Numerically controlled oscillator
   // ------------------------------------------------------------
   // Only the rate is steered; output edges drift within a half period
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mif.pll_en) begin
         nco_cnt <= '0;
         nco_clk <= 1'b0;
      end else if (nco_cnt >= half_per - PER_W'(1)) begin
         nco_cnt <= '0;
         nco_clk <= ~nco_clk; // RULE5
      end else begin
         nco_cnt <= nco_cnt + PER_W'(1);
      end
   end

   // ------------------------------------------------------------
   // Output select, registered
   // ------------------------------------------------------------
   logic next_cpu_clk;

   always_comb begin
      if (mif.presc)       next_cpu_clk = presc_clk; // RULE3
      else if (mif.direct) next_cpu_clk = osc_in;    // RULE2
      else                 next_cpu_clk = nco_clk;   // RULE5
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cpu_clk <= 1'b0;
      end else begin
         cpu_clk <= next_cpu_clk;
      end
   end

   // Mode shown outside is one edge behind the image

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         clock_mode_select <= MODE_RESET;
         pll_active        <= 1'b0;
      end else begin
         clock_mode_select <= mif.mode;
         pll_active        <= mif.pll_en;
      end
   end
endmodule

/* ccg_osc_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Oscillator source, level synchronous to the reference clock
// ------------------------------------------------------------
module ccg_osc_model #(
   parameter int HALF = 60
)
(
   // Reference clock
   input  wire logic ref_clk,
   // Oscillator level
   output logic      osc_in
);
   int cnt = 0;
   initial osc_in = 1'b0;
   always @(posedge ref_clk) begin
      if (cnt == HALF - 1) begin
         cnt <= 0;
         osc_in <= ~osc_in;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* ccg_chk.sv */
`timescale 1ns/1ps
module ccg_chk
   import ccg_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   // Inputs
   input wire logic        osc_in,
   input wire logic [15:0] port0_pins,
   input wire logic [15:0] reset_config_reg,
   input wire logic        reload,
   // Outputs
   input wire logic        cpu_clk,
   input wire logic [2:0]  clock_mode_select,
   input wire logic        pll_active,
   input wire logic        pll_locked
);
   logic [2:0] pin_q;
   logic [2:0] cfg_q;
   logic [7:0] quiet;
   int         cnt;
   int         prev;
   always_ff @(posedge ref_clk) pin_q <= port0_pins[15:13];
   always_ff @(posedge ref_clk) cfg_q <= reset_config_reg[15:13];
   // Settling gate: phase lengths are meaningless right after a mode change
   always_ff @(posedge ref_clk) begin
      if (sys_rst || reload || $changed(clock_mode_select)) quiet <= 8'h0;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h1;
   end
   always_ff @(posedge ref_clk) begin
      if ($changed(cpu_clk)) begin
         prev <= cnt;
         cnt <= 1;
      end else begin
         cnt <= cnt + 1;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rel;  $fell(sys_rst) ##2 1'b1; endsequence
   sequence s_load; reload && !$past(sys_rst) ##2 1'b1; endsequence
   AST_RST: assert property (@(posedge ref_clk) disable iff (1'b0) sys_rst |=>
      !cpu_clk && !pll_active && !pll_locked) else $error("outputs not quiet in reset");
   AST_PINS: assert property (s_rel |-> clock_mode_select == $past(pin_q))
      else $error("mode not taken from pins");
   AST_LOAD: assert property (s_load |-> clock_mode_select == $past(cfg_q))
      else $error("mode not reloaded");
   AST_ACT: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> pll_active ==
      (clock_mode_select != 3'h1 && clock_mode_select != 3'h3)) else $error("loop use wrong");
   AST_DIR: assert property (clock_mode_select == 3'h3 && quiet > 8'h4 |->
      cpu_clk == $past(osc_in)) else $error("direct drive wrong");
   AST_DIV: assert property (clock_mode_select == 3'h1 && quiet > 8'h4 && $rose(osc_in)
      |-> ##2 $changed(cpu_clk)) else $error("prescaler missed a toggle");
   AST_DIVH: assert property (clock_mode_select == 3'h1 && quiet > 8'h4 && !$rose(osc_in)
      |-> ##2 $stable(cpu_clk)) else $error("prescaler phase not one period");
   AST_SMOOTH: assert property (pll_active && quiet == 8'hFF && $changed(cpu_clk)
      |-> cnt <= prev + 1 && prev <= cnt + 1) else $error("loop rate jumped");
endmodule
bind ccg_clock_gen ccg_chk i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .osc_in(osc_in),
   .port0_pins(port0_pins), .reset_config_reg(reset_config_reg), .reload(reload),
   .cpu_clk(cpu_clk), .clock_mode_select(clock_mode_select), .pll_active(pll_active),
   .pll_locked(pll_locked));

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import ccg_pkg::*;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, reload = 1'b0;
   logic        osc_in, cpu_clk, pll_active, pll_locked;
   logic [15:0] port0_pins = 16'h2000, reset_config_reg = 16'h0;
   logic [2:0]  clock_mode_select;
   int          bad_count = 0, tests_run = 0, n;
   // CPU rises per eight oscillator periods, by mode code
   int          exp_r [8] = '{20, 4, 12, 8, 40, 16, 24, 32};
   logic [2:0]  order [8] = '{3'h4, 3'h7, 3'h6, 3'h0, 3'h5, 3'h2, 3'h3, 3'h1};
   initial forever #2.5 ref_clk = ~ref_clk;
   ccg_osc_model #(.HALF(60)) i_osc (.ref_clk(ref_clk), .osc_in(osc_in));
   ccg_clock_gen #(.HALF_INIT(12)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .osc_in(osc_in), .port0_pins(port0_pins), .reset_config_reg(reset_config_reg),
      .reload(reload), .cpu_clk(cpu_clk), .clock_mode_select(clock_mode_select),
      .pll_active(pll_active), .pll_locked(pll_locked));
   task chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task count_rises(output int r);
      logic p;
      r = 0;
      p = cpu_clk;
      repeat (960) begin
         @(posedge ref_clk);
         #1;
         if (cpu_clk === 1'b1 && p === 1'b0) r++;
         p = cpu_clk;
      end
   endtask
   task t_pins;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(clock_mode_select === 3'h1 && pll_active === 1'b0, "pin mode");
      count_rises(n);
      chk(n >= 3 && n <= 5, "prescaler rate");
      // Reload inside reset must be ignored; pins win at release
      @(posedge ref_clk) sys_rst <= 1'b1;
      port0_pins <= 16'h6000;
      reset_config_reg <= 16'hA000;
      reload <= 1'b1;
      @(posedge ref_clk) reload <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(clock_mode_select === 3'h3, "reset release mode");
   endtask
   task t_modes;
      foreach (order[i]) begin
         @(posedge ref_clk) reset_config_reg <= {order[i], 13'h0};
         reload <= 1'b1;
         @(posedge ref_clk) reload <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk(clock_mode_select === order[i], "reload mode");
         chk(pll_active === (order[i] != 3'h1 && order[i] != 3'h3), "loop use");
         for (int k = 0; k < 9000 && pll_active === 1'b1 && pll_locked !== 1'b1; k++)
            @(posedge ref_clk);
         repeat (1200) @(posedge ref_clk);
         chk(pll_active === 1'b1 ? pll_locked === 1'b1 : pll_locked === 1'b0, "loop lock");
         count_rises(n);
         chk(n >= exp_r[order[i]] - 1 && n <= exp_r[order[i]] + 1, "cpu rate");
      end
   endtask
   task print_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #300000;
      bad_count++;
      print_verdict;
   end
   initial begin
      t_pins;
      t_modes;
      print_verdict;
   end
endmodule
